// ==== include/rcr_pkg.sv ====
// Shared constants and types for the regulator control register bank
package rcr_pkg;
  localparam logic [7:0] ADDR_B1_CTRL = 8'h22;
  localparam logic [7:0] ADDR_B2_PRI  = 8'h30;
  localparam logic [7:0] ADDR_B2_SEC  = 8'h31;
  localparam logic [7:0] ADDR_B2_CTRL = 8'h32;
  localparam logic [7:0] ADDR_B3_PRI  = 8'h40;
  localparam logic [7:0] ADDR_B3_SEC  = 8'h41;
  localparam logic [7:0] ADDR_B3_CTRL = 8'h42;
  localparam logic [7:0] ADDR_L1_SET  = 8'h50;
  localparam logic [7:0] ADDR_L1_CTRL = 8'h51;
  localparam logic [7:0] ADDR_L2_SET  = 8'h54;
  localparam logic [7:0] ADDR_L2_CTRL = 8'h55;

  localparam int NUM_REG  = 5;
  localparam int NUM_SET  = 6;
  localparam int NUM_BUCK = 3;
  localparam int NUM_LDO  = 2;
  localparam int SET_W    = 6;
  localparam int DELAY_W  = 3;

  localparam logic [2:0] IDX_B1 = 3'h0;
  localparam logic [2:0] IDX_B2 = 3'h1;
  localparam logic [2:0] IDX_B3 = 3'h2;
  localparam logic [2:0] IDX_L1 = 3'h3;
  localparam logic [2:0] IDX_L2 = 3'h4;

  localparam int BIT_ON    = 7;
  localparam int BIT_SIX   = 6;
  localparam int BIT_FIVE  = 5;
  localparam int DELAY_LSB = 2;
  localparam int BIT_FLT   = 1;
  localparam int BIT_PGOOD = 0;

  localparam logic [7:0] CTRL_WR_MASK = 8'hFE;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [5:0] SET_RST      = 6'h00;
  localparam logic [1:0] RSVD_ZERO    = 2'h0;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_MACK
  } rcr_i2c_state_t;
endpackage : rcr_pkg

// ==== rtl/rcr_i2c_slave.sv ====
// Two-wire serial slave giving byte access to the register bank
`timescale 1ns/10ps
module rcr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [7:0]      regAddr,
  output logic            wrEn,
  output logic [7:0]      wrData,
  input  wire logic [7:0] rdData
);
  rcr_pkg::rcr_i2c_state_t state;
  logic [2:0] sclS;
  logic [2:0] sdaS;
  logic       sclF;
  logic       sdaF;
  logic       sclP;
  logic       sdaP;
  logic [3:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic       readDir;
  logic       masterNack;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclS <= 3'h7;
      sdaS <= 3'h7;
      sclF <= 1'b1;
      sdaF <= 1'b1;
      sclP <= 1'b1;
      sdaP <= 1'b1;
    end else begin
      sclS <= {sclS[1:0], sclIn};
      sdaS <= {sdaS[1:0], sdaIn};
      if (sclS[1] == sclS[2]) sclF <= sclS[2];
      if (sdaS[1] == sdaS[2]) sdaF <= sdaS[2];
      sclP <= sclF;
      sdaP <= sdaF;
    end
  end

  assign sclRise   = sclF & ~sclP;
  assign sclFall   = ~sclF & sclP;
  assign startCond = sclF & sclP & sdaP & ~sdaF;
  assign stopCond  = sclF & sclP & ~sdaP & sdaF;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= rcr_pkg::ST_IDLE;
      bitCnt     <= 4'h0;
      rxShift    <= 8'h00;
      txShift    <= 8'h00;
      readDir    <= 1'b0;
      masterNack <= 1'b0;
      regAddr    <= 8'h00;
      wrEn       <= 1'b0;
      wrData     <= 8'h00;
    end else begin
      wrEn <= 1'b0;
      if (startCond) begin
        state  <= rcr_pkg::ST_ADDR;
        bitCnt <= 4'h0;
      end else if (stopCond) begin
        state <= rcr_pkg::ST_IDLE;
      end else if (sclRise) begin
        if (state == rcr_pkg::ST_ADDR || state == rcr_pkg::ST_REG || state == rcr_pkg::ST_WDATA) begin
          rxShift <= {rxShift[6:0], sdaF};
          bitCnt  <= bitCnt + 4'h1;
        end
        if (state == rcr_pkg::ST_MACK) masterNack <= sdaF;
      end else if (sclFall) begin
        unique case (state)
          rcr_pkg::ST_IDLE: ;
          rcr_pkg::ST_ADDR: if (bitCnt == rcr_pkg::BYTE_BITS) begin
            readDir <= rxShift[0];
            state   <= (rxShift[7:1] == DEV_ADDR) ? rcr_pkg::ST_ACK_ADDR : rcr_pkg::ST_IDLE;
          end
          rcr_pkg::ST_ACK_ADDR: begin
            bitCnt  <= 4'h0;
            txShift <= rdData;
            state   <= readDir ? rcr_pkg::ST_RDATA : rcr_pkg::ST_REG;
          end
          rcr_pkg::ST_REG: if (bitCnt == rcr_pkg::BYTE_BITS) begin
            regAddr <= rxShift;
            state   <= rcr_pkg::ST_ACK_REG;
          end
          rcr_pkg::ST_WDATA: if (bitCnt == rcr_pkg::BYTE_BITS) begin
            wrData <= rxShift;
            wrEn   <= 1'b1;
            state  <= rcr_pkg::ST_ACK_WDATA;
          end
          rcr_pkg::ST_ACK_REG, rcr_pkg::ST_ACK_WDATA: begin
            // Pointer advances after each stored byte for burst writes
            if (state == rcr_pkg::ST_ACK_WDATA) regAddr <= regAddr + 8'h01;
            bitCnt <= 4'h0;
            state  <= rcr_pkg::ST_WDATA;
          end
          rcr_pkg::ST_RDATA: if (bitCnt == rcr_pkg::BYTE_BITS - 4'h1) begin
            regAddr <= regAddr + 8'h01;
            state   <= rcr_pkg::ST_MACK;
          end else begin
            txShift <= {txShift[6:0], 1'b0};
            bitCnt  <= bitCnt + 4'h1;
          end
          rcr_pkg::ST_MACK: begin
            bitCnt  <= 4'h0;
            txShift <= rdData;
            state   <= masterNack ? rcr_pkg::ST_IDLE : rcr_pkg::ST_RDATA;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe  = (state == rcr_pkg::ST_ACK_ADDR) | (state == rcr_pkg::ST_ACK_REG) |
                  (state == rcr_pkg::ST_ACK_WDATA) | ((state == rcr_pkg::ST_RDATA) & ~txShift[7]);
endmodule : rcr_i2c_slave

// ==== rtl/rcr_regulator_bank.sv ====
// Control and status registers for three step-down converters and two linear regulators
// Summary of operation
// - Step-down setpoint follows secondary field while select pin is high.
// - Control bit 7 switches each regulator on or off.
// - Second converter bit 6 selects 180 degree phase shift.
// - Step-down bit 5 forces fixed-frequency operation at all loads.
// - Control bits 4 to 2 hold each regulator's turn-on delay code.
// - Linear regulator delay codes form a group apart from step-down codes.
// - Control bit 1 lets regulator faults raise the interrupt.
// - Control bit 0 reads live power-good status.
// - Third converter bit 6 low lets the push-button enable it.
// - Linear regulator bit 6 discharges output while shut down.
// - Linear regulator bit 5 selects low-quiescent operation.
// - Linear regulators use one 6-bit setpoint, ignoring select pin.
// - All bits return to defaults on supply loss or undervoltage.
`timescale 1ns/10ps
module rcr_regulator_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        setpointSelectPin,
  input  wire logic        pushButtonInput_n,
  input  wire logic [4:0]  regPowerGood,
  input  wire logic [4:0]  regFault,
  output logic [4:0]       regEnable,
  output logic [1:0]       buckPhase180,
  output logic [2:0]       buckPwmForced,
  output logic [8:0]       buckDelayCode,
  output logic [5:0]       ldoDelayCode,
  output logic             faultIrqRequest,
  output logic [5:0]       buck2Setpoint,
  output logic [5:0]       buck3Setpoint,
  output logic [5:0]       ldo1Setpoint,
  output logic [5:0]       ldo2Setpoint,
  output logic [1:0]       ldoOutputDischarge,
  output logic [1:0]       ldoLowQuiescentMode
);
  localparam int SYNC_W = 12;

  logic [7:0]        ctrlReg [rcr_pkg::NUM_REG];
  logic [5:0]        setReg [rcr_pkg::NUM_SET];
  logic [7:0]        regAddr;
  logic              wrEn;
  logic [7:0]        wrData;
  logic [7:0]        rdData;
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] syncF;
  logic              selF;
  logic              pbF;
  logic [4:0]        pgF;
  logic [4:0]        faultF;
  logic              pbSet;
  logic [3:0]        wrCtrl;
  logic [3:0]        wrSet;
  logic [3:0]        rdCtrl;
  logic [3:0]        rdSet;

  // Returns {hit, index} for a control register address
  function automatic logic [3:0] ctrlSel(input logic [7:0] a);
    unique case (a)
      rcr_pkg::ADDR_B1_CTRL: ctrlSel = {1'b1, rcr_pkg::IDX_B1};
      rcr_pkg::ADDR_B2_CTRL: ctrlSel = {1'b1, rcr_pkg::IDX_B2};
      rcr_pkg::ADDR_B3_CTRL: ctrlSel = {1'b1, rcr_pkg::IDX_B3};
      rcr_pkg::ADDR_L1_CTRL: ctrlSel = {1'b1, rcr_pkg::IDX_L1};
      rcr_pkg::ADDR_L2_CTRL: ctrlSel = {1'b1, rcr_pkg::IDX_L2};
      default:               ctrlSel = 4'h0;
    endcase
  endfunction : ctrlSel

  // Returns {hit, index} for a voltage setpoint register address
  function automatic logic [3:0] setSel(input logic [7:0] a);
    unique case (a)
      rcr_pkg::ADDR_B2_PRI: setSel = 4'h8;
      rcr_pkg::ADDR_B2_SEC: setSel = 4'h9;
      rcr_pkg::ADDR_B3_PRI: setSel = 4'hA;
      rcr_pkg::ADDR_B3_SEC: setSel = 4'hB;
      rcr_pkg::ADDR_L1_SET: setSel = 4'hC;
      rcr_pkg::ADDR_L2_SET: setSel = 4'hD;
      default:              setSel = 4'h0;
    endcase
  endfunction : setSel

  rcr_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .regAddr (regAddr),
    .wrEn    (wrEn),
    .wrData  (wrData),
    .rdData  (rdData)
  );

  // Push-button is inverted ahead of the stages so reset means released
  assign syncIn = {regFault, regPowerGood, ~pushButtonInput_n, setpointSelectPin};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      syncF <= '0;
    end else begin
      s1    <= syncIn;
      s2    <= s1;
      s3    <= s2;
      syncF <= (syncF & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
    end
  end

  assign selF   = syncF[0];
  assign pbF    = syncF[1];
  assign pgF    = syncF[6:2];
  assign faultF = syncF[11:7];

  assign wrCtrl = ctrlSel(regAddr);
  assign wrSet  = setSel(regAddr);
  assign rdCtrl = wrCtrl;
  assign rdSet  = wrSet;

  assign pbSet = pbF & ~ctrlReg[rcr_pkg::IDX_B3][rcr_pkg::BIT_SIX];

  // Reset is the supply-loss and undervoltage lockout reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < rcr_pkg::NUM_REG; i++) ctrlReg[i] <= rcr_pkg::CTRL_RST;
    end else begin
      for (int i = 0; i < rcr_pkg::NUM_REG; i++) begin
        if (wrEn && wrCtrl[3] && wrCtrl[2:0] == 3'(i)) ctrlReg[i] <= wrData & rcr_pkg::CTRL_WR_MASK;
      end
      // Button press beats a same-cycle software clear
      if (pbSet) ctrlReg[rcr_pkg::IDX_B3][rcr_pkg::BIT_ON] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < rcr_pkg::NUM_SET; i++) setReg[i] <= rcr_pkg::SET_RST;
    end else begin
      for (int i = 0; i < rcr_pkg::NUM_SET; i++) begin
        if (wrEn && wrSet[3] && wrSet[2:0] == 3'(i)) setReg[i] <= wrData[rcr_pkg::SET_W-1:0];
      end
    end
  end

  // Power-good bit is live status, never the stored bit
  always_comb begin
    rdData = 8'h00;
    if (rdCtrl[3]) begin
      rdData = ctrlReg[rdCtrl[2:0]];
      rdData[rcr_pkg::BIT_PGOOD] = pgF[rdCtrl[2:0]];
    end else if (rdSet[3]) begin
      rdData = {rcr_pkg::RSVD_ZERO, setReg[rdSet[2:0]]};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regEnable     <= '0;
      buckPwmForced <= '0;
      buckDelayCode <= '0;
      ldoDelayCode  <= '0;
    end else begin
      for (int i = 0; i < rcr_pkg::NUM_REG; i++) regEnable[i] <= ctrlReg[i][rcr_pkg::BIT_ON];
      for (int i = 0; i < rcr_pkg::NUM_BUCK; i++) begin
        buckPwmForced[i] <= ctrlReg[i][rcr_pkg::BIT_FIVE];
        buckDelayCode[i*rcr_pkg::DELAY_W +: rcr_pkg::DELAY_W] <=
          ctrlReg[i][rcr_pkg::DELAY_LSB +: rcr_pkg::DELAY_W];
      end
      for (int i = 0; i < rcr_pkg::NUM_LDO; i++) begin
        ldoDelayCode[i*rcr_pkg::DELAY_W +: rcr_pkg::DELAY_W] <=
          ctrlReg[i+rcr_pkg::NUM_BUCK][rcr_pkg::DELAY_LSB +: rcr_pkg::DELAY_W];
      end
    end
  end

  // Third converter's bit 6 is the push-button option, so no phase output
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buckPhase180 <= '0;
    end else begin
      buckPhase180[0] <= ctrlReg[rcr_pkg::IDX_B1][rcr_pkg::BIT_SIX];
      buckPhase180[1] <= ctrlReg[rcr_pkg::IDX_B2][rcr_pkg::BIT_SIX];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      faultIrqRequest <= 1'b0;
    end else begin
      faultIrqRequest <= 1'b0;
      for (int i = 0; i < rcr_pkg::NUM_REG; i++) begin
        if (faultF[i] && ctrlReg[i][rcr_pkg::BIT_FLT]) faultIrqRequest <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buck2Setpoint <= rcr_pkg::SET_RST;
      buck3Setpoint <= rcr_pkg::SET_RST;
    end else begin
      buck2Setpoint <= selF ? setReg[1] : setReg[0];
      buck3Setpoint <= selF ? setReg[3] : setReg[2];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ldo1Setpoint        <= rcr_pkg::SET_RST;
      ldo2Setpoint        <= rcr_pkg::SET_RST;
      ldoOutputDischarge  <= '0;
      ldoLowQuiescentMode <= '0;
    end else begin
      ldo1Setpoint <= setReg[4];
      ldo2Setpoint <= setReg[5];
      for (int i = 0; i < rcr_pkg::NUM_LDO; i++) begin
        ldoOutputDischarge[i] <= ctrlReg[i+rcr_pkg::NUM_BUCK][rcr_pkg::BIT_SIX] &
                                 ~ctrlReg[i+rcr_pkg::NUM_BUCK][rcr_pkg::BIT_ON];
        ldoLowQuiescentMode[i] <= ctrlReg[i+rcr_pkg::NUM_BUCK][rcr_pkg::BIT_FIVE];
      end
    end
  end

  a_primary_setpoint: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !selF |=> buck2Setpoint == $past(setReg[0]))
    else $error("buck2 setpoint not primary with select low");

  a_secondary_setpoint: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    selF ##1 selF |-> buck3Setpoint == $past(setReg[3]))
    else $error("buck3 setpoint not secondary with select high");

  a_enable_write: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wrEn && regAddr == rcr_pkg::ADDR_B2_CTRL |-> ##2 regEnable[1] == $past(wrData[7], 2))
    else $error("enable output does not follow written bit");

  a_phase_output: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 buckPhase180[1] == $past(ctrlReg[1][6]))
    else $error("phase output mismatch");

  a_mode_output: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(ctrlReg[2][5]) |-> buckPwmForced[2] == 1'b0 ##1 buckPwmForced[2])
    else $error("forced PWM output late or early");

  a_buck_delay: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 buckDelayCode[5:3] == $past(ctrlReg[1][4:2]))
    else $error("buck delay code mismatch");

  a_ldo_delay_group: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 ldoDelayCode[5:3] == $past(ctrlReg[4][4:2]))
    else $error("ldo delay code mismatch");

  a_fault_gate: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 faultIrqRequest == $past(|(faultF & {ctrlReg[4][1], ctrlReg[3][1], ctrlReg[2][1],
                                              ctrlReg[1][1], ctrlReg[0][1]})))
    else $error("fault request not gated by enable bits");

  a_pgood_read: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    regAddr == rcr_pkg::ADDR_L1_CTRL |-> rdData[0] == pgF[3] && rdData[7:1] == ctrlReg[3][7:1])
    else $error("power-good readback wrong");

  a_pushbutton_enable: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    pbF && !ctrlReg[2][6] |-> ##1 ctrlReg[2][7] ##1 regEnable[2])
    else $error("push-button did not enable third converter");

  a_output_discharge: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ctrlReg[3][7] |=> !ldoOutputDischarge[0])
    else $error("discharge applied while regulator on");

  a_low_quiescent: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $fell(ctrlReg[4][5]) |=> !ldoLowQuiescentMode[1])
    else $error("low quiescent mode not cleared");

  a_ldo_setpoint: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $changed(selF) |=> ldo1Setpoint == $past(setReg[4]))
    else $error("ldo setpoint disturbed by select pin");

  a_reserved_zero: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rdSet[3] |-> rdData[7:6] == 2'h0)
    else $error("reserved voltage bits not zero");
endmodule : rcr_regulator_bank

// ==== tb/rcr_host_model.sv ====
// Host processor model on the two-wire serial bus
`timescale 1ns/10ps
module rcr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaPull
);
  // Each phase lasts six cycles, above the two a level must hold to pass the slave filter
  localparam int HALF = 6;
  initial begin
    sclOut  = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // Data moves four cycles after the clock fall so it never looks like a start or stop
  task automatic put_bit(input logic b, output logic s);
    sdaPull = ~b;
    tick(HALF);
    sclOut = 1'b1;
    tick(HALF);
    s = sdaWire;
    sclOut = 1'b0;
    tick(4);
  endtask : put_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
    put_bit(nack, s);
  endtask : recv_byte
  task automatic start_cond;
    sdaPull = 1'b1;
    tick(HALF);
    sclOut = 1'b0;
    tick(4);
  endtask : start_cond
  task automatic restart_cond;
    sdaPull = 1'b0;
    tick(HALF);
    sclOut = 1'b1;
    tick(HALF);
    start_cond();
  endtask : restart_cond
  task automatic stop_cond;
    sdaPull = 1'b1;
    tick(HALF);
    sclOut = 1'b1;
    tick(HALF);
    sdaPull = 1'b0;
    tick(HALF);
  endtask : stop_cond
  task automatic probe(input logic [6:0] dev, output logic ok);
    start_cond();
    send_byte({dev, 1'b0}, ok);
    stop_cond();
  endtask : probe
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, k0);
    send_byte(a, k1);
    send_byte(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, k0);
    send_byte(a, k1);
    restart_cond();
    send_byte({DEV_ADDR, 1'b1}, k2);
    recv_byte(1'b1, d);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : rcr_host_model

// ==== tb/tb_rcr_regulator_bank.sv ====
// Self-checking bench for the regulator control register bank
`timescale 1ns/10ps
module tb_rcr_regulator_bank;
  localparam logic [7:0] ADDRS [11] = '{8'h22, 8'h30, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42,
                                        8'h50, 8'h51, 8'h54, 8'h55};
  localparam int CI [5] = '{0, 3, 6, 8, 10};
  logic       ref_clk, reset_n, scl, sdaPull, sdaWire, sdaOut, sdaOe;
  logic       setpointSelectPin, pushButtonInput_n, faultIrqRequest;
  logic [4:0] regPowerGood, regFault, regEnable;
  logic [1:0] buckPhase180, ldoOutputDischarge, ldoLowQuiescentMode;
  logic [2:0] buckPwmForced;
  logic [8:0] buckDelayCode;
  logic [5:0] ldoDelayCode, buck2Setpoint, buck3Setpoint, ldo1Setpoint, ldo2Setpoint;
  logic [7:0] sh [11];
  logic [7:0] d;
  logic       ok;
  int         nMismatch = 0;
  int         checks = 0;
  // Open-drain wire with pull-up
  assign sdaWire = ~(sdaPull | sdaOe);
  rcr_regulator_bank i_rcr_regulator_bank (.ref_clk(ref_clk), .reset_n(reset_n), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .setpointSelectPin(setpointSelectPin),
    .pushButtonInput_n(pushButtonInput_n), .regPowerGood(regPowerGood), .regFault(regFault),
    .regEnable(regEnable), .buckPhase180(buckPhase180), .buckPwmForced(buckPwmForced),
    .buckDelayCode(buckDelayCode), .ldoDelayCode(ldoDelayCode), .faultIrqRequest(faultIrqRequest),
    .buck2Setpoint(buck2Setpoint), .buck3Setpoint(buck3Setpoint), .ldo1Setpoint(ldo1Setpoint),
    .ldo2Setpoint(ldo2Setpoint), .ldoOutputDischarge(ldoOutputDischarge),
    .ldoLowQuiescentMode(ldoLowQuiescentMode));
  rcr_host_model i_rcr_host_model (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(scl), .sdaPull(sdaPull));
  task automatic report_and_stop;
    if (nMismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] exp_rd(input int k);
    for (int i = 0; i < 5; i++) if (CI[i] == k) return (sh[k] & 8'hFE) | {7'h00, regPowerGood[i]};
    return sh[k] & 8'h3F;
  endfunction : exp_rd
  task automatic wr(input int k, input logic [7:0] v);
    i_rcr_host_model.write_reg(ADDRS[k], v, ok);
    chk("write ack", ok, 1);
    sh[k] = v;
  endtask : wr
  task automatic check_regs;
    for (int k = 0; k < 11; k++) begin
      i_rcr_host_model.read_reg(ADDRS[k], d, ok);
      chk("read ack", ok, 1);
      chk("readback", d, exp_rd(k));
    end
  endtask : check_regs
  task automatic check_outs;
    logic [7:0] cr [5];
    logic [4:0] en, fm;
    for (int i = 0; i < 5; i++) begin
      cr[i] = sh[CI[i]];
      en[i] = cr[i][7];
      fm[i] = cr[i][1];
    end
    chk("regEnable", regEnable, en);
    chk("buckPhase180", buckPhase180, {cr[1][6], cr[0][6]});
    chk("buckPwmForced", buckPwmForced, {cr[2][5], cr[1][5], cr[0][5]});
    chk("buckDelayCode", buckDelayCode, {cr[2][4:2], cr[1][4:2], cr[0][4:2]});
    chk("ldoDelayCode", ldoDelayCode, {cr[4][4:2], cr[3][4:2]});
    chk("faultIrqRequest", faultIrqRequest, |(regFault & fm));
    chk("buck2Setpoint", buck2Setpoint, setpointSelectPin ? sh[2][5:0] : sh[1][5:0]);
    chk("buck3Setpoint", buck3Setpoint, setpointSelectPin ? sh[5][5:0] : sh[4][5:0]);
    chk("ldo1Setpoint", ldo1Setpoint, sh[7][5:0]);
    chk("ldo2Setpoint", ldo2Setpoint, sh[9][5:0]);
    chk("ldoOutputDischarge", ldoOutputDischarge, {cr[4][6] & ~cr[4][7], cr[3][6] & ~cr[3][7]});
    chk("ldoLowQuiescentMode", ldoLowQuiescentMode, {cr[4][5], cr[3][5]});
    chk("sdaOut", sdaOut, 0);
  endtask : check_outs
  task automatic do_reset;
    reset_n = 1'b0;
    i_rcr_host_model.tick(16);
    chk("regEnable in reset", regEnable, 0);
    reset_n = 1'b1;
    for (int k = 0; k < 11; k++) sh[k] = 8'h00;
    i_rcr_host_model.tick(8);
    check_outs();
    check_regs();
  endtask : do_reset
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    nMismatch++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    setpointSelectPin = 1'b0;
    pushButtonInput_n = 1'b1;
    regPowerGood = 5'h00;
    regFault = 5'h00;
    void'($urandom(32'h9A23));
    do_reset();
    // Two fixed patterns hit reserved bits and discharge-while-off, then one random round
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 11; k++) wr(k, (r == 0) ? 8'hFF : (r == 1) ? 8'h5E : 8'($urandom));
      setpointSelectPin = 1'($urandom);
      regPowerGood = 5'($urandom);
      regFault = 5'($urandom);
      // Press only while the button is configured to be ignored, so stored bits stay known
      pushButtonInput_n = sh[6][6] ? 1'($urandom) : 1'b1;
      i_rcr_host_model.tick(10);
      check_outs();
      setpointSelectPin = ~setpointSelectPin;
      i_rcr_host_model.tick(10);
      check_outs();
      check_regs();
      pushButtonInput_n = 1'b1;
    end
    i_rcr_host_model.write_reg(8'h23, 8'hFF, ok);
    i_rcr_host_model.read_reg(8'h23, d, ok);
    chk("unmapped read", d, 8'h00);
    i_rcr_host_model.probe(7'h2B, ok);
    chk("foreign address ack", ok, 0);
    wr(6, 8'h00);
    pushButtonInput_n = 1'b0;
    i_rcr_host_model.tick(10);
    chk("button enables buck3", regEnable[2], 1);
    pushButtonInput_n = 1'b1;
    sh[6] = 8'h80;
    wr(6, 8'h40);
    pushButtonInput_n = 1'b0;
    i_rcr_host_model.tick(10);
    chk("button ignored", regEnable[2], 0);
    pushButtonInput_n = 1'b1;
    check_regs();
    do_reset();
    report_and_stop();
  end
endmodule : tb_rcr_regulator_bank
